// ===== core/pac_pkg.sv
package pac_pkg;
	// How it works
	// - Row start register tracks the bus while its latch is low, holds while high.
	// - Column start register tracks the bus while its latch is low, holds while high.
	// - Left row pointer steps one row on each falling edge of its clock.
	// - Right row pointer steps one row on each falling edge of its clock.
	// - Left row sync low presets left pointer to row start; given while clock high.
	// - Right row sync low presets right pointer to row start; given while clock high.
	// - Column sync low presets column pointer from column start; then fall and rise.
	// - Pixel output level is valid while the column clock is low.
	// - Row reset high resets the row addressed by the chosen row pointer.
	// - Row select high selects the chosen pointer's row; normally held high.
	// - Side select picks left pointer when high, right pointer when low.
	// - Calibration high forces unity gain and black reference; pulsed once a frame.
	// - Gain select 00,01,10,11 gives gain 1,2,4,8; lower line is LSB.
	// - Converter converts on each falling edge of its clock.
	// - Bit invert high inverts every result bit; low passes them unchanged.
	// - Output disable high floats the result lines; low drives them.
	// - Result is ten bits wide, least significant line first.
	// - Each pointer drives end-of-scan low for one clock period on passing the last.
	// - Column pointer steps to next pixel on each column clock falling edge.

	localparam int PAC_ADDR_W = 9;
	localparam int PAC_CODE_W = 10;
	localparam int PAC_AXI_AW = 8;
	localparam int PAC_PIN_W  = 28;

	// Register offsets
	localparam logic [PAC_AXI_AW-1:0] PAC_OFS_LIMIT  = 8'h00;
	localparam logic [PAC_AXI_AW-1:0] PAC_OFS_START  = 8'h04;
	localparam logic [PAC_AXI_AW-1:0] PAC_OFS_ROWPTR = 8'h08;
	localparam logic [PAC_AXI_AW-1:0] PAC_OFS_COLPTR = 8'h0c;

	// Field positions inside a register word
	localparam int PAC_LO_POS   = 0;
	localparam int PAC_HI_POS   = 16;
	localparam int PAC_PAST_POS = 9;

	// Values after reset
	localparam logic [PAC_ADDR_W-1:0] PAC_LAST_RST = 9'h1ff;
	localparam logic [PAC_PIN_W-1:0]  PAC_PIN_RST  = 28'h006a800;

	localparam logic [1:0] PAC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PAC_RESP_SLVERR = 2'h2;
	localparam logic [3:0] PAC_GAIN_UNITY  = 4'h1;

	typedef enum logic [1:0] {
		PAC_WR_COLLECT = 2'b00,
		PAC_WR_COMMIT  = 2'b01,
		PAC_WR_ANSWER  = 2'b11
	} pac_wr_state_t;
endpackage

// ===== core/pac_readout_ctrl.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pac_readout_ctrl (
	// Clock and reset
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	// AXI4-Lite write
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [pac_pkg::PAC_AXI_AW-1:0]    awaddr,
	input  wire logic                              wvalid,
	output logic                                   wready,
	input  wire logic [31:0]                       wdata,
	input  wire logic [3:0]                        wstrb,
	output logic                                   bvalid,
	input  wire logic                              bready,
	output logic      [1:0]                        bresp,
	// AXI4-Lite read
	input  wire logic                              arvalid,
	output logic                                   arready,
	input  wire logic [pac_pkg::PAC_AXI_AW-1:0]    araddr,
	output logic                                   rvalid,
	input  wire logic                              rready,
	output logic      [31:0]                       rdata,
	output logic      [1:0]                        rresp,
	// Start address bus and latches, bit 0 is the least significant line
	input  wire logic [pac_pkg::PAC_ADDR_W-1:0]    start_addr,
	input  wire logic                              row_start_latch,
	input  wire logic                              col_start_latch,
	// Row and column shift clocks and syncs
	input  wire logic                              left_row_clock,
	input  wire logic                              left_row_sync_n,
	input  wire logic                              right_row_clock,
	input  wire logic                              right_row_sync_n,
	input  wire logic                              col_clock,
	input  wire logic                              col_sync_n,
	// Row control
	input  wire logic                              row_reset,
	input  wire logic                              row_select,
	input  wire logic                              row_side_left,
	// Column amplifier and output amplifier
	input  wire logic                              col_amp_sample,
	input  wire logic                              col_amp_reset,
	input  wire logic                              amp_cal,
	input  wire logic                              gain_sel_lsb,
	input  wire logic                              gain_sel_msb,
	// Converter control and converted value
	input  wire logic                              adc_clock,
	input  wire logic                              output_bit_invert,
	input  wire logic                              adc_out_disable,
	input  wire logic [pac_pkg::PAC_CODE_W-1:0]    adc_sample,
	// End of scan
	output logic                                   left_row_scan_end_n,
	output logic                                   right_row_scan_end_n,
	output logic                                   column_scan_end_n,
	// Pixel array drive
	output logic      [pac_pkg::PAC_ADDR_W-1:0]    row_addr,
	output logic                                   row_reset_en,
	output logic                                   row_select_en,
	output logic      [pac_pkg::PAC_ADDR_W-1:0]    col_addr,
	output logic                                   col_amp_sample_en,
	output logic                                   col_amp_reset_en,
	output logic                                   pixel_level_valid,
	output logic                                   black_level_reference,
	output logic      [3:0]                        amp_gain_factor,
	// Converter result pins
	output logic      [pac_pkg::PAC_CODE_W-1:0]    pixel_code,
	output logic                                   pixel_code_oe_n
);
	import pac_pkg::*;

	logic [PAC_PIN_W-1:0]  pins_s;
	logic [PAC_ADDR_W-1:0] addr_s;
	logic                  row_latch_s;
	logic                  col_latch_s;
	logic                  lclk_s;
	logic                  lsync_n_s;
	logic                  rclk_s;
	logic                  rsync_n_s;
	logic                  cclk_s;
	logic                  csync_n_s;
	logic                  row_reset_s;
	logic                  row_select_s;
	logic                  row_side_s;
	logic                  amp_s_s;
	logic                  amp_r_s;
	logic                  cal_s;
	logic [1:0]            gain_s;
	logic                  adclk_s;
	logic                  inv_s;
	logic                  dis_s;

	logic                  lclk_prev_q;
	logic                  rclk_prev_q;
	logic                  cclk_prev_q;
	logic                  adclk_prev_q;
	logic                  lclk_fall;
	logic                  rclk_fall;
	logic                  cclk_fall;
	logic                  adc_fall;

	logic [PAC_ADDR_W-1:0] row_start_q;
	logic [PAC_ADDR_W-1:0] col_start_q;
	logic [PAC_ADDR_W-1:0] last_row_q;
	logic [PAC_ADDR_W-1:0] last_col_q;
	logic [PAC_ADDR_W-1:0] left_ptr;
	logic [PAC_ADDR_W-1:0] right_ptr;
	logic                  left_past;
	logic                  right_past;
	logic                  col_past;
	logic [PAC_CODE_W-1:0] adc_result_q;

	pac_wr_state_t         wr_state_q;
	logic [PAC_AXI_AW-1:0] awaddr_q;
	logic [31:0]           wdata_q;
	logic [3:0]            wstrb_q;
	logic                  aw_held_q;
	logic                  w_held_q;
	logic [31:0]           rd_word;
	logic                  rd_hit;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Every control pin crosses two flops before use; adc_sample is taken unsynchronised
	pac_sync #(
		.W   (PAC_PIN_W),
		.RST (PAC_PIN_RST)
	) u_pins (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     ({start_addr, row_start_latch, col_start_latch, left_row_clock,
		           left_row_sync_n, right_row_clock, right_row_sync_n, col_clock,
		           col_sync_n, row_reset, row_select, row_side_left, col_amp_sample,
		           col_amp_reset, amp_cal, gain_sel_msb, gain_sel_lsb, adc_clock,
		           output_bit_invert, adc_out_disable}),
		.pin_s   (pins_s)
	);

	assign {addr_s, row_latch_s, col_latch_s, lclk_s, lsync_n_s, rclk_s, rsync_n_s,
	        cclk_s, csync_n_s, row_reset_s, row_select_s, row_side_s, amp_s_s, amp_r_s,
	        cal_s, gain_s, adclk_s, inv_s, dis_s} = pins_s;

	// Falling edges of the pin clocks, seen at aclk rate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lclk_prev_q  <= 1'b0;
			rclk_prev_q  <= 1'b0;
			cclk_prev_q  <= 1'b0;
			adclk_prev_q <= 1'b0;
		end else begin
			lclk_prev_q  <= lclk_s;
			rclk_prev_q  <= rclk_s;
			cclk_prev_q  <= cclk_s;
			adclk_prev_q <= adclk_s;
		end
	end

	assign lclk_fall = lclk_prev_q && !lclk_s;
	assign rclk_fall = rclk_prev_q && !rclk_s;
	assign cclk_fall = cclk_prev_q && !cclk_s;
	assign adc_fall  = adclk_prev_q && !adclk_s;

	// Start registers behave as transparent latches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			row_start_q <= '0;
		end else if (!row_latch_s) begin
			row_start_q <= addr_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			col_start_q <= '0;
		end else if (!col_latch_s) begin
			col_start_q <= addr_s;
		end
	end

	pac_scan #(.W(PAC_ADDR_W)) u_left (
		.aclk    (aclk),
		.aresetn (aresetn),
		.step    (lclk_fall),
		.preset  (!lsync_n_s),
		.start   (row_start_q),
		.last    (last_row_q),
		.ptr_q   (left_ptr),
		.past_q  (left_past),
		.end_n_q (left_row_scan_end_n)
	);

	pac_scan #(.W(PAC_ADDR_W)) u_right (
		.aclk    (aclk),
		.aresetn (aresetn),
		.step    (rclk_fall),
		.preset  (!rsync_n_s),
		.start   (row_start_q),
		.last    (last_row_q),
		.ptr_q   (right_ptr),
		.past_q  (right_past),
		.end_n_q (right_row_scan_end_n)
	);

	pac_scan #(.W(PAC_ADDR_W)) u_col (
		.aclk    (aclk),
		.aresetn (aresetn),
		.step    (cclk_fall),
		.preset  (!csync_n_s),
		.start   (col_start_q),
		.last    (last_col_q),
		.ptr_q   (col_addr),
		.past_q  (col_past),
		.end_n_q (column_scan_end_n)
	);

	// Row drive follows the chosen side; a pointer past the end addresses no row
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			row_addr      <= '0;
			row_reset_en  <= 1'b0;
			row_select_en <= 1'b0;
		end else if (row_side_s) begin
			row_addr      <= left_ptr;
			row_reset_en  <= row_reset_s && !left_past;
			row_select_en <= row_select_s && !left_past;
		end else begin
			row_addr      <= right_ptr;
			row_reset_en  <= row_reset_s && !right_past;
			row_select_en <= row_select_s && !right_past;
		end
	end

	// Amplifier controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			col_amp_sample_en     <= 1'b0;
			col_amp_reset_en      <= 1'b0;
			pixel_level_valid     <= 1'b0;
			black_level_reference <= 1'b0;
			amp_gain_factor       <= PAC_GAIN_UNITY;
		end else begin
			col_amp_sample_en     <= amp_s_s;
			col_amp_reset_en      <= amp_r_s;
			pixel_level_valid     <= !cclk_s;
			black_level_reference <= cal_s;
			amp_gain_factor       <= cal_s ? PAC_GAIN_UNITY : (PAC_GAIN_UNITY << gain_s);
		end
	end

	// Conversion result and output stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adc_result_q <= '0;
		end else if (adc_fall) begin
			adc_result_q <= adc_sample;
		end
	end

	// Inversion is applied live so a change shows without a new conversion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pixel_code      <= '0;
			pixel_code_oe_n <= 1'b1;
		end else begin
			pixel_code      <= adc_result_q ^ {PAC_CODE_W{inv_s}};
			pixel_code_oe_n <= dis_s;
		end
	end

	// Write path: address and data in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			aw_held_q <= 1'b1;
			awaddr_q  <= awaddr;
		end else if (wr_state_q == PAC_WR_COMMIT) begin
			aw_held_q <= 1'b0;
		end else if (!aw_held_q && wr_state_q == PAC_WR_COLLECT) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready   <= 1'b0;
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			w_held_q <= 1'b1;
			wdata_q  <= wdata;
			wstrb_q  <= wstrb;
		end else if (wr_state_q == PAC_WR_COMMIT) begin
			w_held_q <= 1'b0;
		end else if (!w_held_q && wr_state_q == PAC_WR_COLLECT) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= PAC_WR_COLLECT;
			bvalid     <= 1'b0;
			bresp      <= PAC_RESP_OKAY;
		end else begin
			case (wr_state_q)
				PAC_WR_COLLECT: begin
					if (aw_held_q && w_held_q) begin
						wr_state_q <= PAC_WR_COMMIT;
					end
				end
				PAC_WR_COMMIT: begin
					wr_state_q <= PAC_WR_ANSWER;
					bvalid     <= 1'b1;
					bresp      <= (awaddr_q[PAC_AXI_AW-1:2] == PAC_OFS_LIMIT[PAC_AXI_AW-1:2])
					              ? PAC_RESP_OKAY : PAC_RESP_SLVERR;
				end
				PAC_WR_ANSWER: begin
					if (bready) begin
						bvalid     <= 1'b0;
						wr_state_q <= PAC_WR_COLLECT;
					end
				end
				default: begin
					wr_state_q <= PAC_WR_COLLECT;
					bvalid     <= 1'b0;
				end
			endcase
		end
	end

	// Scan limits, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_row_q <= PAC_LAST_RST;
			last_col_q <= PAC_LAST_RST;
		end else if (wr_state_q == PAC_WR_COMMIT
		             && awaddr_q[PAC_AXI_AW-1:2] == PAC_OFS_LIMIT[PAC_AXI_AW-1:2]) begin
			if (wstrb_q[0]) last_row_q[7:0] <= wdata_q[PAC_LO_POS+7:PAC_LO_POS];
			if (wstrb_q[1]) last_row_q[8]   <= wdata_q[PAC_LO_POS+8];
			if (wstrb_q[2]) last_col_q[7:0] <= wdata_q[PAC_HI_POS+7:PAC_HI_POS];
			if (wstrb_q[3]) last_col_q[8]   <= wdata_q[PAC_HI_POS+8];
		end
	end

	// Read decode
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case ({araddr[PAC_AXI_AW-1:2], 2'b00})
			PAC_OFS_LIMIT: begin
				rd_word[PAC_LO_POS +: PAC_ADDR_W] = last_row_q;
				rd_word[PAC_HI_POS +: PAC_ADDR_W] = last_col_q;
			end
			PAC_OFS_START: begin
				rd_word[PAC_LO_POS +: PAC_ADDR_W] = row_start_q;
				rd_word[PAC_HI_POS +: PAC_ADDR_W] = col_start_q;
			end
			PAC_OFS_ROWPTR: begin
				rd_word[PAC_LO_POS +: PAC_ADDR_W]   = left_ptr;
				rd_word[PAC_LO_POS + PAC_PAST_POS]  = left_past;
				rd_word[PAC_HI_POS +: PAC_ADDR_W]   = right_ptr;
				rd_word[PAC_HI_POS + PAC_PAST_POS]  = right_past;
			end
			PAC_OFS_COLPTR: begin
				rd_word[PAC_LO_POS +: PAC_ADDR_W]   = col_addr;
				rd_word[PAC_LO_POS + PAC_PAST_POS]  = col_past;
				rd_word[PAC_HI_POS +: PAC_CODE_W]   = adc_result_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= PAC_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_hit ? PAC_RESP_OKAY : PAC_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	property p_row_track;
		!row_latch_s |=> row_start_q == $past(addr_s);
	endproperty
	a_row_track: assert property (p_row_track) else $error("row start not tracking");

	property p_row_hold;
		row_latch_s ##1 row_latch_s |-> $stable(row_start_q);
	endproperty
	a_row_hold: assert property (p_row_hold) else $error("row start not held");

	property p_col_hold;
		col_latch_s ##1 col_latch_s |-> $stable(col_start_q);
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("column start not held");

	property p_left_preset;
		!lsync_n_s |=> left_ptr == $past(row_start_q) && !left_past;
	endproperty
	a_left_preset: assert property (p_left_preset) else $error("left preset failed");

	property p_right_step;
		rclk_fall && rsync_n_s && !right_past && right_ptr != last_row_q
		|=> right_ptr == $past(right_ptr) + 1'b1;
	endproperty
	a_right_step: assert property (p_right_step) else $error("right pointer stuck");

	property p_col_preset;
		!csync_n_s |=> col_addr == $past(col_start_q) && column_scan_end_n;
	endproperty
	a_col_preset: assert property (p_col_preset) else $error("column preset failed");

	property p_pix_valid;
		cclk_s |=> !pixel_level_valid;
	endproperty
	a_pix_valid: assert property (p_pix_valid) else $error("pixel valid while clock high");

	property p_row_side;
		!row_side_s && row_reset_s && !right_past
		|=> row_reset_en && row_addr == $past(right_ptr);
	endproperty
	a_row_side: assert property (p_row_side) else $error("wrong row side reset");

	property p_cal;
		cal_s |=> black_level_reference && amp_gain_factor == PAC_GAIN_UNITY;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration not unity");

	property p_gain;
		!cal_s && gain_s == 2'h3 |=> amp_gain_factor == 4'h8;
	endproperty
	a_gain: assert property (p_gain) else $error("gain eight not set");

	property p_convert;
		adc_fall |=> ##1 pixel_code == ($past(adc_sample, 2) ^ {PAC_CODE_W{$past(inv_s)}});
	endproperty
	a_convert: assert property (p_convert) else $error("converted code wrong");

	property p_float;
		dis_s |=> pixel_code_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated");
endmodule

// ===== core/pac_scan.sv
`timescale 1ns/1ns
module pac_scan #(
	parameter int W = 9
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Control
	input  wire logic         step,
	input  wire logic         preset,
	input  wire logic [W-1:0] start,
	input  wire logic [W-1:0] last,
	// State
	output logic      [W-1:0] ptr_q,
	output logic              past_q,
	output logic              end_n_q
);
	// Preset is level sensitive and beats a step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_q  <= '0;
			past_q <= 1'b0;
		end else if (preset) begin
			ptr_q  <= start;
			past_q <= 1'b0;
		end else if (step && !past_q) begin
			if (ptr_q == last) begin
				past_q <= 1'b1;
			end else begin
				ptr_q <= ptr_q + 1'b1;
			end
		end
	end

	// Low from the step past the last entry to the following step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			end_n_q <= 1'b1;
		end else if (preset) begin
			end_n_q <= 1'b1;
		end else if (step) begin
			end_n_q <= !(!past_q && ptr_q == last);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_end_low;
		!preset && step && !past_q && ptr_q == last |=> !end_n_q ##0 past_q;
	endproperty
	a_end_low: assert property (p_end_low) else $error("end of scan not flagged");

	property p_end_release;
		!preset && step && !end_n_q |=> end_n_q;
	endproperty
	a_end_release: assert property (p_end_release) else $error("end of scan held too long");

	property p_step;
		!preset && step && !past_q && ptr_q != last |=> ptr_q == $past(ptr_q) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("pointer did not advance");
endmodule

// ===== core/pac_sync.sv
`timescale 1ns/1ns
module pac_sync #(
	parameter int                 W   = 1,
	parameter logic [W-1:0]       RST = '0
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Pins in, synchronised out
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] pin_s
);
	logic [W-1:0] meta_q;

	// Two stages per bit; only the second stage is ever read
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				meta_q[i] <= RST[i];
				pin_s[i]  <= RST[i];
			end else begin
				meta_q[i] <= pin[i];
				pin_s[i]  <= meta_q[i];
			end
		end
	end
endmodule

// ===== tb/pac_ctrl_model.sv
`timescale 1ns/1ns
module pac_ctrl_model (
	// Clock
	input  wire logic       aclk,
	// Start address and latches
	output logic      [8:0] start_addr,
	output logic            row_start_latch,
	output logic            col_start_latch,
	// Shift clocks and syncs
	output logic            left_row_clock,
	output logic            left_row_sync_n,
	output logic            right_row_clock,
	output logic            right_row_sync_n,
	output logic            col_clock,
	output logic            col_sync_n,
	// Row, amplifier and converter control
	output logic            row_reset,
	output logic            row_select,
	output logic            row_side_left,
	output logic            col_amp_sample,
	output logic            col_amp_reset,
	output logic            amp_cal,
	output logic            gain_sel_lsb,
	output logic            gain_sel_msb,
	output logic            adc_clock,
	output logic            output_bit_invert,
	output logic            adc_out_disable,
	output logic      [9:0] adc_sample
);
	logic [3:0] clk_q;
	logic [2:0] sync_n_q;
	logic [9:0] lvl_q;
	assign {adc_clock, col_clock, right_row_clock, left_row_clock} = clk_q;
	assign {row_reset, row_select, row_side_left, col_amp_sample, col_amp_reset, amp_cal,
	        gain_sel_msb, gain_sel_lsb, output_bit_invert, adc_out_disable} = lvl_q;
	assign {col_sync_n, right_row_sync_n, left_row_sync_n} = sync_n_q;
	initial begin
		clk_q = '1;
		sync_n_q = '1;
		start_addr = '0;
		{row_start_latch, col_start_latch} = 2'h3;
		lvl_q = 10'h100;
		adc_sample = '0;
	end
	// Every level is held six edges, well past the two-flop sampling
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Bus stays put across both latch transitions
	task automatic load(input logic col, input logic [8:0] a);
		start_addr <= a;
		if (col) col_start_latch <= 1'b0;
		else row_start_latch <= 1'b0;
		tick(6);
		{row_start_latch, col_start_latch} <= 2'h3;
		tick(6);
	endtask
	task automatic drive_clk(input int k, input logic v);
		clk_q[k] <= v;
		tick(6);
	endtask
	task automatic level(input int k, input logic v);
		lvl_q[k] <= v;
		tick(6);
	endtask
	// Code is set up together with the falling edge that converts it
	task automatic convert(input logic [9:0] code);
		adc_sample <= code;
		drive_clk(3, 1'b0);
	endtask
	// Clocks idle high, so sync always falls inside the high phase
	task automatic sync(input int k);
		sync_n_q[k] <= 1'b0;
		tick(6);
		sync_n_q[k] <= 1'b1;
		tick(6);
	endtask
	task automatic step(input int k);
		drive_clk(k, 1'b0);
		drive_clk(k, 1'b1);
	endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
	import pac_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_q;
	logic [3:0] wstrb, amp_gain_factor;
	logic [1:0] bresp, rresp;
	logic [8:0] start_addr, row_addr, col_addr;
	logic [9:0] adc_sample, pixel_code;
	logic row_start_latch, col_start_latch, left_row_clock, left_row_sync_n, right_row_clock;
	logic right_row_sync_n, col_clock, col_sync_n, row_reset, row_select, row_side_left;
	logic col_amp_sample, col_amp_reset, amp_cal, gain_sel_lsb, gain_sel_msb, adc_clock;
	logic output_bit_invert, adc_out_disable, left_row_scan_end_n, right_row_scan_end_n;
	logic column_scan_end_n, row_reset_en, row_select_en, col_amp_sample_en, col_amp_reset_en;
	logic pixel_level_valid, black_level_reference, pixel_code_oe_n;
	int errors, total_checks, cycles;
	pac_readout_ctrl dut (.*);
	pac_ctrl_model ctl (.*);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic close_out();
		if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		// Valids read here still show the value before this edge's update
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid | wvalid);
		while (!bvalid) @(posedge aclk);
		bready <= 1'b0;
		chk(bresp, e);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] e);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		rd_q = rdata;
		chk(rresp, e);
		@(posedge aclk);
	endtask
	task automatic s_regs();
		rd(PAC_OFS_LIMIT, PAC_RESP_OKAY);
		chk(rd_q, 32'h01ff01ff);
		wr(PAC_OFS_LIMIT, 32'h00040006, 4'h5, PAC_RESP_OKAY);
		rd(PAC_OFS_LIMIT, PAC_RESP_OKAY);
		chk(rd_q, 32'h01040106);
		wr(PAC_OFS_LIMIT, 32'h00040006, 4'hf, PAC_RESP_OKAY);
		wr(8'h10, 32'h0, 4'hf, PAC_RESP_SLVERR);
		rd(PAC_OFS_LIMIT, PAC_RESP_OKAY);
		chk(rd_q, 32'h00040006);
		rd(8'h10, PAC_RESP_SLVERR);
		chk(rd_q, 32'h0);
	endtask
	task automatic s_rows();
		ctl.load(1'b0, 9'h005);
		ctl.start_addr <= 9'h009;
		ctl.tick(6);
		rd(PAC_OFS_START, PAC_RESP_OKAY);
		chk(rd_q[8:0], 9'h005);
		ctl.level(7, 1'b1);
		ctl.sync(0);
		chk(row_addr, 9'h005);
		ctl.step(0);
		chk(row_addr, 9'h006);
		ctl.step(0);
		chk(left_row_scan_end_n, 1'b0);
		ctl.level(7, 1'b0);
		ctl.sync(1);
		chk(row_addr, 9'h005);
		ctl.step(1);
		chk(row_addr, 9'h006);
		ctl.level(9, 1'b1);
		chk(row_reset_en, 1'b1);
		chk(row_select_en, 1'b1);
		ctl.level(8, 1'b0);
		chk(row_select_en, 1'b0);
		ctl.level(8, 1'b1);
		ctl.level(9, 1'b0);
		chk(row_reset_en, 1'b0);
		ctl.level(7, 1'b1);
		chk(row_select_en, 1'b0);
		ctl.step(1);
		chk(right_row_scan_end_n, 1'b0);
	endtask
	task automatic s_col();
		ctl.load(1'b1, 9'h003);
		ctl.sync(2);
		chk(col_addr, 9'h003);
		ctl.drive_clk(2, 1'b0);
		chk(col_addr, 9'h004);
		chk(pixel_level_valid, 1'b1);
		ctl.drive_clk(2, 1'b1);
		chk(pixel_level_valid, 1'b0);
		ctl.step(2);
		chk(column_scan_end_n, 1'b0);
	endtask
	task automatic s_amp();
		for (int g = 0; g < 4; g++) begin
			ctl.level(3, g[1]);
			ctl.level(2, g[0]);
			chk(amp_gain_factor, 4'h1 << g);
		end
		ctl.level(4, 1'b1);
		chk(amp_gain_factor, PAC_GAIN_UNITY);
		chk(black_level_reference, 1'b1);
		ctl.level(4, 1'b0);
		ctl.level(6, 1'b1);
		chk(col_amp_sample_en, 1'b1);
		chk(black_level_reference, 1'b0);
		ctl.level(6, 1'b0);
		ctl.level(5, 1'b1);
		chk(col_amp_reset_en, 1'b1);
		chk(col_amp_sample_en, 1'b0);
	endtask
	task automatic s_adc();
		ctl.convert(10'h2a5);
		chk(pixel_code, 10'h2a5);
		chk(pixel_code_oe_n, 1'b0);
		ctl.drive_clk(3, 1'b1);
		ctl.level(1, 1'b1);
		chk(pixel_code, 10'h15a);
		ctl.convert(10'h0f0);
		chk(pixel_code, 10'h30f);
		ctl.level(0, 1'b1);
		chk(pixel_code_oe_n, 1'b1);
	endtask
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_regs();
		s_rows();
		s_col();
		s_amp();
		s_adc();
		close_out();
	end
endmodule
